// ---- logic/scp_defines.svh ----
// Register indices, field positions, reset values and widths of the serial clock control block.
// Assumes it is included by bare name from the package and design modules.
`ifndef SCP_DEFINES_SVH
`define SCP_DEFINES_SVH

// Register indices; the AXI byte address is four times the index.
`define SCP_IDX_W 22
`define SCP_IDX_CLOCK_ENABLE 22'h0f00f0
`define SCP_IDX_CHANNEL_CTRL 22'h0f0120
`define SCP_IDX_PRESCALER 22'h0f0126
`define SCP_IDX_NOISE_FILTER 22'h0f0128
`define SCP_ADDR_W 24

// Clock enable bit positions.
`define SCP_BIT_TIMER 0
`define SCP_BIT_SERIAL 2
`define SCP_BIT_CONVERTER 5
`define SCP_BIT_COMPARATOR 6
`define SCP_BIT_INTERVAL 7

// Writable masks of the clock enable register for the two package variants.
`define SCP_MASK_SMALL 8'h25
`define SCP_MASK_LARGE 8'he5

// Prescaler field positions.
`define SCP_UPPER_LSB 4
`define SCP_LOWER_LSB 0
`define SCP_DIV_FIELD_W 4

// Channel control field positions.
`define SCP_CH_START_LSB 0
`define SCP_CH_STOP_LSB 2
`define SCP_CH_CHOICE_LSB 4

// Reset values.
`define SCP_CLOCK_ENABLE_RESET 8'h00
`define SCP_PRESCALER_RESET 8'h00
`define SCP_CHANNEL_RESET 4'h0
`define SCP_NOISE_FILTER_RESET 8'h00

// Prescaler counter width gives dividers up to two to the fifteenth.
`define SCP_COUNT_W 15

// AXI response codes.
`define SCP_RESP_OKAY 2'h0
`define SCP_RESP_SLVERR 2'h2

`endif

// ---- logic/scp_pkg.sv ----
// Types shared by the serial clock control block.
// Assumes the constants header sits in the include path.
`include "scp_defines.svh"

package scp_pkg;

   // Peripheral clock enable register, bit 7 down to bit 0.
   typedef struct packed {
      logic interval_timer_clock_on;
      logic comparator_clock_on;
      logic converter_clock_on;
      logic [1:0] unused_hi;
      logic serial_unit_clock_on;
      logic unused_lo;
      logic timer_unit_clock_on;
   } scp_clock_enable_t;

   // Prescaler select register: upper divider in the high nibble.
   typedef struct packed {
      logic [3:0] upper_divider;
      logic [3:0] lower_divider;
   } scp_prescaler_t;

   // Channel state: clock choice and operation enable status per channel.
   typedef struct packed {
      logic [1:0] channel_clock_choice;
      logic [1:0] channel_enable_status;
   } scp_channel_t;

endpackage : scp_pkg

// ---- logic/scp_prescaler.sv ----
// Shared prescaler producing the two operation clock enables.
// Assumes a single system clock and a synchronous active-high reset.
`timescale 1ns/1ps
`include "scp_defines.svh"

module scp_prescaler #(
   parameter int COUNT_W = `SCP_COUNT_W
) (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic rst_i,
   // Control.
   input wire logic enable_i,
   input wire logic [3:0] lower_div_i,
   input wire logic [3:0] upper_div_i,
   // Prescaled enable pulses.
   output logic lower_tick_o,
   output logic upper_tick_o
);

   logic [COUNT_W-1:0] count;
   logic [COUNT_W-1:0] next_count;
   logic lower_hit;
   logic upper_hit;

   // A divider k fires when the low k counter bits are all ones; k of zero fires every cycle.
   function automatic logic div_hit(input logic [COUNT_W-1:0] cnt, input logic [3:0] k);
      logic [COUNT_W-1:0] mask;
      mask = ~({COUNT_W{1'b1}} << k);
      div_hit = ((cnt & mask) == mask);
   endfunction : div_hit

   // Counter is held clear while the unit clock is off, so dividers restart in phase.
   assign next_count = enable_i ? count + 1'b1 : '0;
   assign lower_hit = enable_i && div_hit(count, lower_div_i);
   assign upper_hit = enable_i && div_hit(count, upper_div_i);

   // One free-running counter serves both dividers.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         count <= '0;
         lower_tick_o <= 1'b0;
         upper_tick_o <= 1'b0;
      end else begin
         count <= next_count;
         lower_tick_o <= lower_hit;
         upper_tick_o <= upper_hit;
      end
   end

endmodule : scp_prescaler

// ---- logic/scp_clock_control.sv ----
// Clock gating, reset hold and prescaler registers of a two-channel serial unit.
// Assumes an AXI4-Lite master on SYS_CLK_I and the serial unit on the same clock.
`timescale 1ns/1ps
`include "scp_defines.svh"

module scp_clock_control #(
   parameter bit LARGE_VARIANT = 1'b1,
   parameter int COUNT_W = `SCP_COUNT_W
) (
   // Clock and reset.
   input wire logic SYS_CLK_I,
   input wire logic RST_I,
   // AXI4-Lite write address channel.
   input wire logic [`SCP_ADDR_W-1:0] AWADDR_I,
   input wire logic [2:0] AWPROT_I,
   input wire logic AWVALID_I,
   output logic AWREADY_O,
   // AXI4-Lite write data channel.
   input wire logic [31:0] WDATA_I,
   input wire logic [3:0] WSTRB_I,
   input wire logic WVALID_I,
   output logic WREADY_O,
   // AXI4-Lite write response channel.
   output logic [1:0] BRESP_O,
   output logic BVALID_O,
   input wire logic BREADY_I,
   // AXI4-Lite read address channel.
   input wire logic [`SCP_ADDR_W-1:0] ARADDR_I,
   input wire logic [2:0] ARPROT_I,
   input wire logic ARVALID_I,
   output logic ARREADY_O,
   // AXI4-Lite read data channel.
   output logic [31:0] RDATA_O,
   output logic [1:0] RRESP_O,
   output logic RVALID_O,
   input wire logic RREADY_I,
   // Gated peripheral clock enables.
   output logic TIMER_CLK_ON_O,
   output logic SERIAL_CLK_ON_O,
   output logic CONVERTER_CLK_ON_O,
   output logic COMPARATOR_CLK_ON_O,
   output logic INTERVAL_TIMER_CLK_ON_O,
   // Serial unit reset hold, active high.
   output logic SERIAL_RESET_O,
   // Operation clock enables to the serial channels.
   output logic LOWER_TICK_O,
   output logic UPPER_TICK_O,
   output logic [1:0] CHANNEL_TICK_O,
   output logic [1:0] CHANNEL_ENABLE_O,
   // Noise filter setting, kept while the unit is off.
   output logic [7:0] NOISE_FILTER_O
);

   // Register state.
   scp_pkg::scp_clock_enable_t clock_enable;
   scp_pkg::scp_prescaler_t prescaler;
   scp_pkg::scp_channel_t channel;
   logic [7:0] noise_filter;

   // Write channel holding registers.
   logic aw_held;
   logic [`SCP_ADDR_W-1:0] aw_addr;
   logic w_held;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic bvalid;
   logic [1:0] bresp;

   // Read channel registers.
   logic rvalid;
   logic [1:0] rresp;
   logic [31:0] rdata;

   // Decode wires.
   logic do_write;
   logic [`SCP_IDX_W-1:0] wr_idx;
   logic [`SCP_IDX_W-1:0] rd_idx;
   logic wr_enable_hit;
   logic wr_prescaler_hit;
   logic wr_channel_hit;
   logic wr_noise_hit;
   logic wr_mapped;
   logic rd_mapped;
   logic byte_lane;
   logic unit_on;
   logic [7:0] enable_mask;
   logic [7:0] read_word;
   logic lower_tick;
   logic upper_tick;

   // Next values.
   scp_pkg::scp_clock_enable_t next_clock_enable;
   scp_pkg::scp_prescaler_t next_prescaler;
   scp_pkg::scp_channel_t next_channel;
   logic [7:0] next_noise_filter;
   logic [1:0] next_status;
   logic [1:0] start_req;
   logic [1:0] stop_req;

   // A byte address maps to the register index held in its upper bits.
   // Bits 1:0 are dropped, so an unaligned address reaches the word that holds it.
   function automatic logic [`SCP_IDX_W-1:0] index_of(input logic [`SCP_ADDR_W-1:0] addr);
      index_of = addr[`SCP_ADDR_W-1:2];
   endfunction : index_of

   // Index decode used by both the read and the write path.
   // Anything else answers SLVERR on both paths and changes nothing.
   function automatic logic is_mapped(input logic [`SCP_IDX_W-1:0] idx);
      is_mapped = (idx == `SCP_IDX_CLOCK_ENABLE) || (idx == `SCP_IDX_PRESCALER) ||
         (idx == `SCP_IDX_CHANNEL_CTRL) || (idx == `SCP_IDX_NOISE_FILTER);
   endfunction : is_mapped

   // Per-channel operation clock pick; a stopped channel passes no ticks.
   function automatic logic channel_tick(input logic enabled, input logic choice,
         input logic upper, input logic lower);
      channel_tick = enabled && (choice ? upper : lower);
   endfunction : channel_tick

   // The comparator and interval timer bits only exist on the large variant.
   assign enable_mask = LARGE_VARIANT ? `SCP_MASK_LARGE : `SCP_MASK_SMALL;
   // Every unit register and the prescaler key off this single bit.
   assign unit_on = clock_enable.serial_unit_clock_on;

   // Write path: both halves must be held and the previous response taken.
   // Address and data are latched as soon as each is offered, so either may come first.
   // Both readies stay low until the pair has executed; they rise again while the response may still
   // be pending, and the !bvalid term of do_write keeps a second write from overtaking it.
   assign AWREADY_O = !aw_held;
   assign WREADY_O = !w_held;
   assign do_write = aw_held && w_held && !bvalid;
   assign wr_idx = index_of(aw_addr);
   assign wr_mapped = is_mapped(wr_idx);
   assign byte_lane = w_strb[0]; // Registers live in the low byte lane only.
   assign wr_enable_hit = do_write && byte_lane && (wr_idx == `SCP_IDX_CLOCK_ENABLE);
   assign wr_noise_hit = do_write && byte_lane && (wr_idx == `SCP_IDX_NOISE_FILTER);
   // Unit registers accept nothing while the unit clock is stopped.
   assign wr_prescaler_hit = do_write && byte_lane && unit_on &&
      (wr_idx == `SCP_IDX_PRESCALER);
   assign wr_channel_hit = do_write && byte_lane && unit_on &&
      (wr_idx == `SCP_IDX_CHANNEL_CTRL);

   // Bits outside the variant mask are stored as zero, so a stray write cannot switch on
   // a clock that does not exist on the smaller package.
   // Clock enable register takes any byte write; bit writes arrive as read-modify-write.
   assign next_clock_enable = wr_enable_hit ?
      scp_pkg::scp_clock_enable_t'(w_data[7:0] & enable_mask) : clock_enable;

   // Prescaler update, whole byte only; held at reset value while the unit is off.
   // A rewrite while a channel runs is not blocked; keeping the dividers steady then
   // is software's duty, as a change takes effect at the very next counter compare.
   assign next_prescaler = !unit_on ? scp_pkg::scp_prescaler_t'(`SCP_PRESCALER_RESET) :
      wr_prescaler_hit ? scp_pkg::scp_prescaler_t'(w_data[7:0]) : prescaler;

   // Start and stop requests; a stop in the same write wins so both can be stopped at once.
   // Software stops both channels this way before it changes the system clock.
   assign start_req = wr_channel_hit ? w_data[`SCP_CH_START_LSB +: 2] : 2'h0;
   assign stop_req = wr_channel_hit ? w_data[`SCP_CH_STOP_LSB +: 2] : 2'h0;
   assign next_status = (channel.channel_enable_status | start_req) & ~stop_req;

   // Channel state is forced to its reset value while the unit is held in reset.
   // Holding the state at reset while the unit is off means that a later power-up always
   // starts with both channels stopped and both on the lower operation clock.
   always_comb begin
      next_channel = channel;
      if (!unit_on) begin
         next_channel = scp_pkg::scp_channel_t'(`SCP_CHANNEL_RESET);
      end else begin
         next_channel.channel_enable_status = next_status;
         if (wr_channel_hit) begin
            next_channel.channel_clock_choice = w_data[`SCP_CH_CHOICE_LSB +: 2];
         end
      end
   end

   // The noise filter register stays writable whatever the unit clock does.
   // It shapes pin inputs, so it has to keep its setting while the unit sleeps.
   assign next_noise_filter = wr_noise_hit ? w_data[7:0] : noise_filter;

   // Register file; reset clears everything.
   // Only the clock enable and noise filter registers keep their contents while the unit
   // is powered down; the prescaler and channel state fall back to their defaults.
   always_ff @(posedge SYS_CLK_I) begin
      if (RST_I) begin
         clock_enable <= scp_pkg::scp_clock_enable_t'(`SCP_CLOCK_ENABLE_RESET);
         prescaler <= scp_pkg::scp_prescaler_t'(`SCP_PRESCALER_RESET);
         channel <= scp_pkg::scp_channel_t'(`SCP_CHANNEL_RESET);
         noise_filter <= `SCP_NOISE_FILTER_RESET;
      end else begin
         clock_enable <= next_clock_enable;
         prescaler <= next_prescaler;
         channel <= next_channel;
         noise_filter <= next_noise_filter;
      end
   end

   // Write address and data may arrive in either order; each is held until used.
   // The latched address is kept after use; only the held flag is cleared.
   always_ff @(posedge SYS_CLK_I) begin
      if (RST_I) begin
         aw_held <= 1'b0;
         aw_addr <= '0;
      end else if (AWVALID_I && !aw_held) begin
         aw_held <= 1'b1;
         aw_addr <= AWADDR_I;
      end else if (do_write) begin
         aw_held <= 1'b0;
      end
   end

   // Write data holding register.
   // The strobes are latched with the data; only the low lane reaches a register.
   always_ff @(posedge SYS_CLK_I) begin
      if (RST_I) begin
         w_held <= 1'b0;
         w_data <= 32'h0;
         w_strb <= 4'h0;
      end else if (WVALID_I && !w_held) begin
         w_held <= 1'b1;
         w_data <= WDATA_I;
         w_strb <= WSTRB_I;
      end else if (do_write) begin
         w_held <= 1'b0;
      end
   end

   // Write response: refused writes to a stopped unit still answer OKAY, as they are silent.
   // An unmapped index answers SLVERR and leaves every register untouched.
   always_ff @(posedge SYS_CLK_I) begin
      if (RST_I) begin
         bvalid <= 1'b0;
         bresp <= `SCP_RESP_OKAY;
      end else if (do_write) begin
         bvalid <= 1'b1;
         bresp <= wr_mapped ? `SCP_RESP_OKAY : `SCP_RESP_SLVERR;
      end else if (BREADY_I) begin
         bvalid <= 1'b0;
      end
   end

   // Response outputs come straight from their flops.
   assign BVALID_O = bvalid;
   assign BRESP_O = bresp;

   // Read decode; unit registers show their reset value from the second cycle the unit is off.
   assign rd_idx = index_of(ARADDR_I);
   assign rd_mapped = is_mapped(rd_idx);
   always_comb begin
      read_word = 8'h00;
      case (rd_idx)
         `SCP_IDX_CLOCK_ENABLE: begin
            read_word = clock_enable;
         end
         `SCP_IDX_PRESCALER: begin
            read_word = prescaler; // Reset value forced from the cycle after the unit goes off.
         end
         `SCP_IDX_CHANNEL_CTRL: begin
            read_word = {2'h0, channel.channel_clock_choice, 2'h0,
               channel.channel_enable_status};
         end
         `SCP_IDX_NOISE_FILTER: begin
            read_word = noise_filter;
         end
         default: begin
            read_word = 8'h00;
         end
      endcase
   end

   // One read at a time; the address is taken only while no answer is pending.
   // The answer comes one cycle after the address is taken, and the data sits in a flop
   // so that it stays steady however long the master waits to take it.
   assign ARREADY_O = !rvalid;
   always_ff @(posedge SYS_CLK_I) begin
      if (RST_I) begin
         rvalid <= 1'b0;
         rdata <= 32'h0;
         rresp <= `SCP_RESP_OKAY;
      end else if (ARVALID_I && !rvalid) begin
         rvalid <= 1'b1;
         rdata <= {24'h0, read_word};
         rresp <= rd_mapped ? `SCP_RESP_OKAY : `SCP_RESP_SLVERR;
      end else if (RREADY_I) begin
         rvalid <= 1'b0;
      end
   end

   // Read outputs come straight from their flops.
   assign RVALID_O = rvalid;
   assign RDATA_O = rdata;
   assign RRESP_O = rresp;

   // Shared prescaler; it stops and clears with the unit clock.
   // Both ticks lag the counter state that made them by one cycle; the channels only
   // see the spacing of the ticks, so the lag does no harm.
   scp_prescaler #(
      .COUNT_W(COUNT_W)
   ) u_prescaler (
      .clk_i(SYS_CLK_I),
      .rst_i(RST_I),
      .enable_i(unit_on),
      .lower_div_i(prescaler.lower_divider),
      .upper_div_i(prescaler.upper_divider),
      .lower_tick_o(lower_tick),
      .upper_tick_o(upper_tick)
   );

   // Gated clock enables straight from the register bits.
   // These levels tell the gates of the other peripherals when to open; no clock is
   // gated inside this block, which keeps the whole design on one clock.
   assign TIMER_CLK_ON_O = clock_enable.timer_unit_clock_on;
   assign SERIAL_CLK_ON_O = unit_on;
   assign CONVERTER_CLK_ON_O = clock_enable.converter_clock_on;
   assign COMPARATOR_CLK_ON_O = clock_enable.comparator_clock_on;
   assign INTERVAL_TIMER_CLK_ON_O = clock_enable.interval_timer_clock_on;

   // The unit stays in reset for as long as its clock is stopped.
   // The reset is the plain inverse of the enable bit, so the unit leaves reset in the
   // same cycle in which its clock enable rises.
   assign SERIAL_RESET_O = !unit_on;

   // Each channel picks its operation clock; a stopped channel gets no ticks.
   assign LOWER_TICK_O = lower_tick;
   assign UPPER_TICK_O = upper_tick;
   assign CHANNEL_TICK_O[0] = channel_tick(channel.channel_enable_status[0],
      channel.channel_clock_choice[0], upper_tick, lower_tick);
   assign CHANNEL_TICK_O[1] = channel_tick(channel.channel_enable_status[1],
      channel.channel_clock_choice[1], upper_tick, lower_tick);
   assign CHANNEL_ENABLE_O = channel.channel_enable_status;
   assign NOISE_FILTER_O = noise_filter;

endmodule : scp_clock_control

// ---- testbench/scp_clock_control_monitor.sv ----
// Port-level checks for the serial clock control block.
// Assumes one clock domain and a synchronous active-high reset; bound from the bench.
`timescale 1ns/1ps

module scp_clock_control_monitor (
   // Clock and reset.
   input wire logic SYS_CLK_I,
   input wire logic RST_I,
   // Bus handshakes.
   input wire logic AWVALID_I,
   input wire logic AWREADY_O,
   input wire logic WVALID_I,
   input wire logic WREADY_O,
   input wire logic [1:0] BRESP_O,
   input wire logic BVALID_O,
   input wire logic BREADY_I,
   input wire logic ARVALID_I,
   input wire logic ARREADY_O,
   input wire logic [31:0] RDATA_O,
   input wire logic RVALID_O,
   input wire logic RREADY_I,
   // Clock control outputs.
   input wire logic TIMER_CLK_ON_O,
   input wire logic SERIAL_CLK_ON_O,
   input wire logic SERIAL_RESET_O,
   input wire logic LOWER_TICK_O,
   input wire logic UPPER_TICK_O,
   input wire logic [1:0] CHANNEL_TICK_O,
   input wire logic [1:0] CHANNEL_ENABLE_O
);
   default clocking cb @(posedge SYS_CLK_I); endclocking
   default disable iff (RST_I);

   // A write is counted here only when address and data are both handed over in the same cycle.
   sequence wr_take;
      AWVALID_I && AWREADY_O && WVALID_I && WREADY_O;
   endsequence
   sequence rd_take;
      ARVALID_I && ARREADY_O;
   endsequence

   AST_RESET_FOLLOW: assert property (SERIAL_RESET_O == !SERIAL_CLK_ON_O)
      else $error("serial reset does not follow the clock enable");
   AST_CH_OFF: assert property ((!SERIAL_CLK_ON_O)[*2] |-> CHANNEL_ENABLE_O == 2'h0)
      else $error("channel enabled while unit is off");
   AST_TICKS_OFF: assert property ((!SERIAL_CLK_ON_O)[*3] |-> !LOWER_TICK_O && !UPPER_TICK_O)
      else $error("prescaler ticks while unit is off");
   AST_CH_GATE: assert property ((CHANNEL_TICK_O & ~CHANNEL_ENABLE_O) == 2'h0)
      else $error("stopped channel receives ticks");
   AST_CH_SRC: assert property (|CHANNEL_TICK_O |-> LOWER_TICK_O || UPPER_TICK_O)
      else $error("channel tick without a prescaled tick");
   AST_WR_ANSWER: assert property (wr_take |-> ##[1:2] BVALID_O)
      else $error("write not answered");
   AST_RD_ANSWER: assert property (rd_take |=> RVALID_O)
      else $error("read not answered");
   AST_B_HOLD: assert property (BVALID_O && !BREADY_I |=> BVALID_O && $stable(BRESP_O))
      else $error("write response dropped early");
   AST_R_HOLD: assert property (RVALID_O && !RREADY_I |=> RVALID_O && $stable(RDATA_O))
      else $error("read data dropped early");
   AST_RESET_VAL: assert property ($fell(RST_I) |-> !SERIAL_CLK_ON_O && !TIMER_CLK_ON_O)
      else $error("clock enables not cleared by reset");
endmodule : scp_clock_control_monitor

// ---- testbench/test_scp_clock_control.sv ----
// Self-checking bench for the serial clock control block.
// Assumes the design and constants header are compiled first.
`timescale 1ns/1ps
`include "scp_defines.svh"

module test_scp_clock_control;
   localparam logic [23:0] A_CE = {`SCP_IDX_CLOCK_ENABLE, 2'b00};
   localparam logic [23:0] A_PS = {`SCP_IDX_PRESCALER, 2'b00};
   localparam logic [23:0] A_CH = {`SCP_IDX_CHANNEL_CTRL, 2'b00};
   localparam logic [23:0] A_NF = {`SCP_IDX_NOISE_FILTER, 2'b00};
   localparam logic [1:0] OK = `SCP_RESP_OKAY;
   logic SYS_CLK_I, RST_I, AWVALID_I, WVALID_I, BREADY_I, ARVALID_I, RREADY_I;
   logic [23:0] AWADDR_I, ARADDR_I;
   logic [31:0] WDATA_I, RDATA_O;
   logic [1:0] BRESP_O, RRESP_O, CHANNEL_TICK_O, CHANNEL_ENABLE_O;
   logic AWREADY_O, WREADY_O, BVALID_O, ARREADY_O, RVALID_O, SERIAL_RESET_O;
   logic TIMER_CLK_ON_O, SERIAL_CLK_ON_O, CONVERTER_CLK_ON_O;
   logic COMPARATOR_CLK_ON_O, INTERVAL_TIMER_CLK_ON_O, LOWER_TICK_O, UPPER_TICK_O;
   logic [7:0] NOISE_FILTER_O;
   int err_count = 0;
   int n_tests = 0;

   // Protection is unused by the block and all strobes stay on, so every write reaches the low lane.
   scp_clock_control #(.LARGE_VARIANT(1'b1), .COUNT_W(15)) dut (
      .SYS_CLK_I(SYS_CLK_I), .RST_I(RST_I), .AWADDR_I(AWADDR_I), .AWPROT_I(3'h0),
      .AWVALID_I(AWVALID_I), .AWREADY_O(AWREADY_O), .WDATA_I(WDATA_I), .WSTRB_I(4'hf),
      .WVALID_I(WVALID_I), .WREADY_O(WREADY_O), .BRESP_O(BRESP_O), .BVALID_O(BVALID_O),
      .BREADY_I(BREADY_I), .ARADDR_I(ARADDR_I), .ARPROT_I(3'h0), .ARVALID_I(ARVALID_I),
      .ARREADY_O(ARREADY_O), .RDATA_O(RDATA_O), .RRESP_O(RRESP_O), .RVALID_O(RVALID_O),
      .RREADY_I(RREADY_I), .TIMER_CLK_ON_O(TIMER_CLK_ON_O), .SERIAL_CLK_ON_O(SERIAL_CLK_ON_O),
      .CONVERTER_CLK_ON_O(CONVERTER_CLK_ON_O), .COMPARATOR_CLK_ON_O(COMPARATOR_CLK_ON_O),
      .INTERVAL_TIMER_CLK_ON_O(INTERVAL_TIMER_CLK_ON_O), .SERIAL_RESET_O(SERIAL_RESET_O),
      .LOWER_TICK_O(LOWER_TICK_O), .UPPER_TICK_O(UPPER_TICK_O),
      .CHANNEL_TICK_O(CHANNEL_TICK_O), .CHANNEL_ENABLE_O(CHANNEL_ENABLE_O),
      .NOISE_FILTER_O(NOISE_FILTER_O));

   // Clock at 100 MHz.
   initial begin
      SYS_CLK_I = 1'b0;
      forever #5 SYS_CLK_I = ~SYS_CLK_I;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic summarize;
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : summarize

   // Ready is raised late on purpose, so the held-response path is exercised.
   task automatic wr(input logic [23:0] a, input logic [7:0] d, input logic [1:0] er);
      int n = 0;
      AWADDR_I <= a;
      WDATA_I <= {24'h0, d};
      AWVALID_I <= 1'b1;
      WVALID_I <= 1'b1;
      while (n < 200) begin
         @(posedge SYS_CLK_I);
         n++;
         if (AWVALID_I && AWREADY_O) AWVALID_I <= 1'b0;
         if (WVALID_I && WREADY_O) WVALID_I <= 1'b0;
         if (BVALID_O && BREADY_I) begin
            check(BRESP_O, er);
            BREADY_I <= 1'b0;
            break;
         end else if (BVALID_O) BREADY_I <= 1'b1;
      end
      check(n < 200, 1'b1);
   endtask : wr

   task automatic rd(input logic [23:0] a, input logic [7:0] exp, input logic [1:0] er);
      int n = 0;
      ARADDR_I <= a;
      ARVALID_I <= 1'b1;
      while (n < 200) begin
         @(posedge SYS_CLK_I);
         n++;
         if (ARVALID_I && ARREADY_O) ARVALID_I <= 1'b0;
         if (RVALID_O && RREADY_I) begin
            check(RDATA_O, {24'h0, exp});
            check(RRESP_O, er);
            RREADY_I <= 1'b0;
            break;
         end else if (RVALID_O) RREADY_I <= 1'b1;
      end
      check(n < 200, 1'b1);
   endtask : rd

   // Cycles between two ticks of one prescaled clock.
   task automatic period(input bit up, input int exp);
      int n = 0;
      while (!(up ? UPPER_TICK_O : LOWER_TICK_O) && n < 70000) begin
         @(posedge SYS_CLK_I);
         n++;
      end
      n = 0;
      do begin
         @(posedge SYS_CLK_I);
         n++;
      end while (!(up ? UPPER_TICK_O : LOWER_TICK_O) && n < 70000);
      check(n, exp);
   endtask : period

   task automatic t_off;
      check({TIMER_CLK_ON_O, SERIAL_CLK_ON_O, CONVERTER_CLK_ON_O}, 3'h0); // Cleared.
      check(SERIAL_RESET_O, 1'b1); // Held.
      rd(A_CE, 8'h00, OK); // Cleared.
      wr(A_PS, 8'h35, OK);
      rd(A_PS, 8'h00, OK); // Write ignored.
      wr(A_CH, 8'h01, OK);
      rd(A_CH, 8'h00, OK); // Write ignored.
      wr(A_NF, 8'h5a, OK);
      rd(A_NF, 8'h5a, OK); // Still writable.
      check(NOISE_FILTER_O, 8'h5a); // Pin value follows.
      wr(24'h000010, 8'h11, `SCP_RESP_SLVERR);
      rd(24'h000010, 8'h00, `SCP_RESP_SLVERR);
   endtask : t_off

   task automatic t_on;
      wr(A_CE, 8'he5, OK); // Unit on first, unused bits zero.
      rd(A_CE, 8'he5, OK); // All enable bits stored.
      check({INTERVAL_TIMER_CLK_ON_O, COMPARATOR_CLK_ON_O, CONVERTER_CLK_ON_O,
             SERIAL_CLK_ON_O, TIMER_CLK_ON_O, SERIAL_RESET_O}, 6'h3e); // All on.
      wr(A_CE, 8'he4, OK);
      check(TIMER_CLK_ON_O, 1'b0); // Single bit cleared.
      rd(A_PS, 8'h00, OK); // Default divider.
      period(1'b0, 1); // Undivided.
      period(1'b1, 1); // Undivided.
   endtask : t_on

   task automatic t_div;
      logic [7:0] tab [3] = '{8'h50, 8'h1f, 8'ha3};
      foreach (tab[i]) begin
         wr(A_PS, tab[i], OK);
         rd(A_PS, tab[i], OK); // Stored.
         period(1'b0, 1 << tab[i][3:0]); // Low nibble.
         period(1'b1, 1 << tab[i][7:4]); // High nibble.
      end
   endtask : t_div

   task automatic t_chan;
      wr(A_PS, 8'h21, OK); // Channels still stopped.
      wr(A_CH, 8'h01, OK);
      check(CHANNEL_ENABLE_O, 2'h1); // Enabled.
      rd(A_CH, 8'h01, OK); // Status.
      wr(A_CH, 8'h13, OK);
      repeat (8) begin
         @(posedge SYS_CLK_I);
         check(CHANNEL_TICK_O, {LOWER_TICK_O, UPPER_TICK_O}); // Per-channel choice.
      end
      wr(A_CH, 8'h0f, OK); // Stop both at once.
      check(CHANNEL_ENABLE_O, 2'h0); // Both stopped.
      wr(A_CH, 8'h02, OK);
      wr(A_CE, 8'h00, OK);
      check({CHANNEL_ENABLE_O, SERIAL_RESET_O}, 3'h1); // Unit reset.
      rd(A_PS, 8'h00, OK); // Default.
      rd(A_CH, 8'h00, OK); // Default.
      rd(A_NF, 8'h5a, OK); // Kept.
      repeat (8) begin
         @(posedge SYS_CLK_I);
         check({LOWER_TICK_O, UPPER_TICK_O}, 2'h0); // Counter held.
      end
   endtask : t_chan

   task automatic t_rereset;
      wr(A_CE, 8'h24, OK);
      RST_I <= 1'b1;
      repeat (2) @(posedge SYS_CLK_I);
      RST_I <= 1'b0;
      @(posedge SYS_CLK_I);
      rd(A_CE, 8'h00, OK); // Cleared again.
   endtask : t_rereset

   // Main sequence; reset is held for 20 cycles first.
   initial begin
      RST_I = 1'b1;
      {AWVALID_I, WVALID_I, BREADY_I, ARVALID_I, RREADY_I} = 5'h0;
      AWADDR_I = 24'h0;
      ARADDR_I = 24'h0;
      WDATA_I = 32'h0;
      repeat (20) @(posedge SYS_CLK_I);
      RST_I <= 1'b0;
      @(posedge SYS_CLK_I);
      t_off;
      t_on;
      t_div;
      t_chan;
      t_rereset;
      summarize;
   end

   // The longest divider takes about 66000 cycles, so this leaves ample margin.
   initial begin
      #1000000;
      err_count++;
      summarize;
   end
endmodule : test_scp_clock_control

bind scp_clock_control scp_clock_control_monitor u_mon (
   .SYS_CLK_I(SYS_CLK_I), .RST_I(RST_I), .AWVALID_I(AWVALID_I), .AWREADY_O(AWREADY_O),
   .WVALID_I(WVALID_I), .WREADY_O(WREADY_O), .BRESP_O(BRESP_O), .BVALID_O(BVALID_O),
   .BREADY_I(BREADY_I), .ARVALID_I(ARVALID_I), .ARREADY_O(ARREADY_O), .RDATA_O(RDATA_O),
   .RVALID_O(RVALID_O), .RREADY_I(RREADY_I), .TIMER_CLK_ON_O(TIMER_CLK_ON_O),
   .SERIAL_CLK_ON_O(SERIAL_CLK_ON_O), .SERIAL_RESET_O(SERIAL_RESET_O),
   .LOWER_TICK_O(LOWER_TICK_O), .UPPER_TICK_O(UPPER_TICK_O),
   .CHANNEL_TICK_O(CHANNEL_TICK_O), .CHANNEL_ENABLE_O(CHANNEL_ENABLE_O));
